/* File: design/dfau_alu.v */
`timescale 1ns/10ps
`include "dfau_consts.vh"

// Pure combinational arithmetic for the supported add instructions.
module dfau_alu (
  // Operation and operands
  input wire [2:0] op,
  input wire [31:0] src_a,
  input wire [31:0] src_b,
  // Results
  output reg [31:0] result,
  output reg sat_hit,
  output reg carry_out
);

  // Halving halfword add: 17-bit interim sum, optional round, keep bits 16..1.
  function [15:0] dfau_half16;
    input [15:0] a;
    input [15:0] b;
    input rnd;
    reg [16:0] t;
    begin
      t = {a[15], a} + {b[15], b} + {16'h0000, rnd};
      dfau_half16 = t[16:1];
    end
  endfunction

  reg [32:0] sum_s;
  reg [32:0] sum_u;

  always @* begin
    sum_s = {src_a[31], src_a} + {src_b[31], src_b};
    sum_u = {1'b0, src_a} + {1'b0, src_b};
    result = 32'h0000_0000;
    sat_hit = 1'b0;
    carry_out = 1'b0;
    case (op)
      `DFAU_OP_SAT_WORD: begin
        if (sum_s[32] != sum_s[31]) begin
          sat_hit = 1'b1;
          result = sum_s[32] ? `DFAU_SAT_NEG : `DFAU_SAT_POS;
        end else begin
          result = sum_s[31:0];
        end
      end
      `DFAU_OP_HALV_PH: begin
        result = {dfau_half16(src_a[31:16], src_b[31:16], 1'b0),
                  dfau_half16(src_a[15:0], src_b[15:0], 1'b0)};
      end
      `DFAU_OP_RHALV_PH: begin
        result = {dfau_half16(src_a[31:16], src_b[31:16], 1'b1),
                  dfau_half16(src_a[15:0], src_b[15:0], 1'b1)};
      end
      `DFAU_OP_HALV_W: begin
        result = sum_s[32:1];
      end
      `DFAU_OP_RHALV_W: begin
        sum_s = sum_s + 33'h0_0000_0001;
        result = sum_s[32:1];
      end
      `DFAU_OP_SET_CARRY: begin
        result = sum_u[31:0];
        carry_out = sum_u[32];
      end
      default: begin
        result = 32'h0000_0000;
      end
    endcase
  end

endmodule

/* File: design/dfau_consts.vh */
`ifndef DFAU_CONSTS_VH
`define DFAU_CONSTS_VH

// Instruction word fields.
`define DFAU_MAJOR_HI 31
`define DFAU_MAJOR_LO 26
`define DFAU_SRCB_HI 25
`define DFAU_SRCB_LO 21
`define DFAU_SRCA_HI 20
`define DFAU_SRCA_LO 16
`define DFAU_DEST_HI 15
`define DFAU_DEST_LO 11
`define DFAU_MAJOR_GROUP 6'h00

// Minor codes in bits 10..0; the 10-bit ones also require bit 10 low.
`define DFAU_MIN_SAT_WORD 11'h305
`define DFAU_MIN_HALV_PH 11'h04D
`define DFAU_MIN_RHALV_PH 11'h44D
`define DFAU_MIN_HALV_W 11'h08D
`define DFAU_MIN_RHALV_W 11'h48D
`define DFAU_MIN_SET_CARRY 11'h385

// Status register fields and reset value.
`define DFAU_OUFLAG_BIT 20
`define DFAU_CARRY_BIT 13
`define DFAU_CTL_RESET 32'h0000_0000

// Saturation limits.
`define DFAU_SAT_POS 32'h7FFF_FFFF
`define DFAU_SAT_NEG 32'h8000_0000

// Operation select codes between decoder and datapath.
`define DFAU_OP_NONE 3'h0
`define DFAU_OP_SAT_WORD 3'h1
`define DFAU_OP_HALV_PH 3'h2
`define DFAU_OP_RHALV_PH 3'h3
`define DFAU_OP_HALV_W 3'h4
`define DFAU_OP_RHALV_W 3'h5
`define DFAU_OP_SET_CARRY 3'h6

`endif

/* File: design/dfau_top.v */
`timescale 1ns/10ps
`include "dfau_consts.vh"

// Function
// - Saturating word add clamps to limits
// - Saturating overflow sets status bit 20
// - Halving halfword add keeps bits 16..1
// - Rounding halfword add adds one first
// - Halving word add keeps bits 32..1
// - Rounding word add adds one first
// - Halving adds leave status untouched
// - Set-carry add writes carry to bit 13
// - Set-carry add leaves overflow flag alone
// - Absent or disabled module raises exceptions
module dfau_top (
  // Clock and reset
  input wire CLK,
  input wire RST_N,
  // Instruction issue from the decoder
  input wire ISSUE_VALID,
  input wire [31:0] INSTR_WORD,
  input wire UNIT_PRESENT,
  input wire UNIT_ENABLED,
  // Source operands from the register file, read at the named fields
  input wire [31:0] SRC_A_DATA,
  input wire [31:0] SRC_B_DATA,
  // Source register indices sent to the register file
  output reg [4:0] SRC_A_IDX,
  output reg [4:0] SRC_B_IDX,
  // Result writeback
  output reg WB_VALID,
  output reg [4:0] WB_IDX,
  output reg [31:0] WB_DATA,
  // Exceptions
  output reg EXC_RESERVED,
  output reg EXC_DISABLED,
  // Control/status register image
  input wire CTL_WR,
  input wire [31:0] CTL_WDATA,
  output reg [31:0] CTL_STATUS
);

  // One-hot pipeline states: idle, operands being fetched, execute.
  localparam ST_IDLE = 3'b001;
  localparam ST_FETCH = 3'b010;
  localparam ST_EXEC = 3'b100;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [2:0] op_q;
  reg [2:0] op_d;
  reg [4:0] dest_q;
  wire [31:0] alu_result;
  wire alu_sat;
  wire alu_carry;
  wire issue_hit;
  reg exc_reserved_d;
  reg exc_disabled_d;
  reg wb_valid_d;
  reg [4:0] wb_idx_d;
  reg [31:0] wb_data_d;
  reg [31:0] status_d;
  reg [4:0] src_a_idx_d;
  reg [4:0] src_b_idx_d;
  reg [4:0] dest_d;

  // Maps the instruction word to an operation code; zero when not ours.
  function [2:0] dfau_decode;
    input [31:0] w;
    reg [10:0] mn;
    begin
      mn = w[10:0];
      dfau_decode = `DFAU_OP_NONE;
      if (w[`DFAU_MAJOR_HI:`DFAU_MAJOR_LO] == `DFAU_MAJOR_GROUP) begin
        case (mn)
          `DFAU_MIN_SAT_WORD: dfau_decode = `DFAU_OP_SAT_WORD;
          `DFAU_MIN_HALV_PH: dfau_decode = `DFAU_OP_HALV_PH;
          `DFAU_MIN_RHALV_PH: dfau_decode = `DFAU_OP_RHALV_PH;
          `DFAU_MIN_HALV_W: dfau_decode = `DFAU_OP_HALV_W;
          `DFAU_MIN_RHALV_W: dfau_decode = `DFAU_OP_RHALV_W;
          `DFAU_MIN_SET_CARRY: dfau_decode = `DFAU_OP_SET_CARRY;
          default: dfau_decode = `DFAU_OP_NONE;
        endcase
      end
    end
  endfunction

  dfau_alu dfau_alu_inst (
    .op(op_q),
    .src_a(SRC_A_DATA),
    .src_b(SRC_B_DATA),
    .result(alu_result),
    .sat_hit(alu_sat),
    .carry_out(alu_carry)
  );

  always @* begin
    op_d = dfau_decode(INSTR_WORD);
    state_d = ST_IDLE;
    case (state_q)
      ST_IDLE: begin
        if (ISSUE_VALID && op_d != `DFAU_OP_NONE && UNIT_PRESENT && UNIT_ENABLED) begin
          state_d = ST_FETCH;
        end
      end
      ST_FETCH: state_d = ST_EXEC;
      ST_EXEC: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // An offer is taken only while idle and only for a word that decodes.
  assign issue_hit = (state_q == ST_IDLE) && ISSUE_VALID && (op_d != `DFAU_OP_NONE);

  // Exceptions depend only on presence and enable, never on the operands.
  always @* begin
    exc_reserved_d = 1'b0;
    exc_disabled_d = 1'b0;
    if (issue_hit) begin
      exc_reserved_d = !UNIT_PRESENT;
      exc_disabled_d = UNIT_PRESENT && !UNIT_ENABLED;
    end
  end

  // Indices stay on the register file ports until the next accepted offer.
  always @* begin
    src_a_idx_d = SRC_A_IDX;
    src_b_idx_d = SRC_B_IDX;
    dest_d = dest_q;
    if (issue_hit) begin
      src_b_idx_d = INSTR_WORD[`DFAU_SRCB_HI:`DFAU_SRCB_LO];
      src_a_idx_d = INSTR_WORD[`DFAU_SRCA_HI:`DFAU_SRCA_LO];
      dest_d = INSTR_WORD[`DFAU_DEST_HI:`DFAU_DEST_LO];
    end
  end

  // The valid pulse lasts one cycle; index and data hold until the next result.
  always @* begin
    wb_valid_d = 1'b0;
    wb_idx_d = WB_IDX;
    wb_data_d = WB_DATA;
    if (state_q == ST_EXEC) begin
      wb_valid_d = 1'b1;
      wb_idx_d = dest_q;
      wb_data_d = alu_result;
    end
  end

  // A software write loses, bit for bit, to a same-cycle hardware update.
  always @* begin
    status_d = CTL_STATUS;
    if (CTL_WR) begin
      status_d = CTL_WDATA;
    end
    if (state_q == ST_EXEC) begin
      case (op_q)
        `DFAU_OP_SAT_WORD: begin
          if (alu_sat) begin
            status_d[`DFAU_OUFLAG_BIT] = 1'b1;
          end
        end
        `DFAU_OP_SET_CARRY: begin
          // Only the carry bit moves; the overflow flag keeps its value.
          status_d[`DFAU_CARRY_BIT] = alu_carry;
        end
        default: begin
          // Halving adds leave every status field as it stands.
          status_d = CTL_WR ? CTL_WDATA : CTL_STATUS;
        end
      endcase
    end
  end

  always @(posedge CLK) begin
    if (!RST_N) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always @(posedge CLK) begin
    if (!RST_N) begin
      op_q <= `DFAU_OP_NONE;
      dest_q <= 5'h00;
      SRC_A_IDX <= 5'h00;
      SRC_B_IDX <= 5'h00;
    end else begin
      if (issue_hit) begin
        op_q <= op_d;
      end
      dest_q <= dest_d;
      SRC_A_IDX <= src_a_idx_d;
      SRC_B_IDX <= src_b_idx_d;
    end
  end

  always @(posedge CLK) begin
    if (!RST_N) begin
      EXC_RESERVED <= 1'b0;
      EXC_DISABLED <= 1'b0;
    end else begin
      EXC_RESERVED <= exc_reserved_d;
      EXC_DISABLED <= exc_disabled_d;
    end
  end

  always @(posedge CLK) begin
    if (!RST_N) begin
      WB_VALID <= 1'b0;
      WB_IDX <= 5'h00;
      WB_DATA <= 32'h0000_0000;
    end else begin
      WB_VALID <= wb_valid_d;
      WB_IDX <= wb_idx_d;
      WB_DATA <= wb_data_d;
    end
  end

  always @(posedge CLK) begin
    if (!RST_N) begin
      CTL_STATUS <= `DFAU_CTL_RESET;
    end else begin
      CTL_STATUS <= status_d;
    end
  end

endmodule

/* File: tb/dfau_monitor.sv */
`timescale 1ns/10ps
`include "dfau_consts.vh"
module dfau_monitor (
  input wire CLK, RST_N, UNIT_PRESENT, UNIT_ENABLED, WB_VALID, EXC_RESERVED, EXC_DISABLED,
  input wire CTL_WR,
  input wire [31:0] INSTR_WORD, SRC_A_DATA, SRC_B_DATA, WB_DATA, CTL_STATUS,
  input wire [4:0] SRC_A_IDX, SRC_B_IDX, WB_IDX
);
  // Issue word three edges back lines up with the writeback pulse.
  reg [95:0] w;
  reg [32:0] s, u;
  wire [10:0] m = w[74:64];
  wire [32:0] r = s + 33'h0_0000_0001;
  always @(posedge CLK) begin
    w <= {w[63:0], INSTR_WORD};
    s <= {SRC_A_DATA[31], SRC_A_DATA} + {SRC_B_DATA[31], SRC_B_DATA};
    u <= {1'b0, SRC_A_DATA} + {1'b0, SRC_B_DATA};
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_dest_index: assert property (WB_VALID |-> WB_IDX == w[79:75]
    && SRC_A_IDX == w[84:80] && SRC_B_IDX == w[89:85]) else $error("wrong register index");
  a_sat_value: assert property (WB_VALID && m == `DFAU_MIN_SAT_WORD |-> WB_DATA ==
    (s[32] == s[31] ? s[31:0] : s[32] ? `DFAU_SAT_NEG : `DFAU_SAT_POS)) else $error("bad clamp");
  a_sat_flag: assert property (WB_VALID && m == `DFAU_MIN_SAT_WORD && s[32] != s[31]
    |-> CTL_STATUS[20]) else $error("flag not set");
  a_halv_word: assert property (WB_VALID && m == `DFAU_MIN_HALV_W |-> WB_DATA == s[32:1])
    else $error("bad halving word");
  a_round_word: assert property (WB_VALID && m == `DFAU_MIN_RHALV_W |-> WB_DATA == r[32:1])
    else $error("bad rounded word");
  a_halv_status: assert property (WB_VALID && m[5:0] == 6'h0D && !$past(CTL_WR)
    |-> $stable(CTL_STATUS)) else $error("status changed");
  a_carry_result: assert property (WB_VALID && m == `DFAU_MIN_SET_CARRY
    |-> WB_DATA == u[31:0] && CTL_STATUS[13] == u[32]) else $error("bad carry add");
  a_carry_flag: assert property (WB_VALID && m == `DFAU_MIN_SET_CARRY && !$past(CTL_WR)
    |-> $stable(CTL_STATUS[20])) else $error("flag touched");
  a_exc_absent: assert property (EXC_RESERVED |-> !$past(UNIT_PRESENT))
    else $error("spurious reserved");
  a_exc_off: assert property (EXC_DISABLED |-> $past(UNIT_PRESENT) && !$past(UNIT_ENABLED))
    else $error("spurious disabled");
endmodule
bind dfau_top dfau_monitor dfau_monitor_inst (.CLK(CLK), .RST_N(RST_N),
  .UNIT_PRESENT(UNIT_PRESENT), .UNIT_ENABLED(UNIT_ENABLED), .WB_VALID(WB_VALID),
  .EXC_RESERVED(EXC_RESERVED), .EXC_DISABLED(EXC_DISABLED), .CTL_WR(CTL_WR),
  .INSTR_WORD(INSTR_WORD), .SRC_A_DATA(SRC_A_DATA), .SRC_B_DATA(SRC_B_DATA),
  .WB_DATA(WB_DATA), .CTL_STATUS(CTL_STATUS), .SRC_A_IDX(SRC_A_IDX),
  .SRC_B_IDX(SRC_B_IDX), .WB_IDX(WB_IDX));

/* File: tb/dfau_regs.sv */
`timescale 1ns/10ps
// Register file seen by the unit; the bench loads it directly.
module dfau_regs (
  input wire [4:0] a_idx,
  input wire [4:0] b_idx,
  output wire [31:0] a_data,
  output wire [31:0] b_data
);
  reg [31:0] mem [0:31];
  assign a_data = mem[a_idx];
  assign b_data = mem[b_idx];
endmodule

/* File: tb/dfau_top_bench.sv */
`timescale 1ns/10ps
`include "dfau_consts.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module dfau_top_bench;
  reg CLK = 0, RST_N = 0, ISSUE_VALID = 0, UNIT_PRESENT = 1, UNIT_ENABLED = 1, CTL_WR = 0;
  reg [31:0] INSTR_WORD = 0, CTL_WDATA = 0;
  wire [31:0] SRC_A_DATA, SRC_B_DATA, WB_DATA, CTL_STATUS;
  wire [4:0] SRC_A_IDX, SRC_B_IDX, WB_IDX;
  wire WB_VALID, EXC_RESERVED, EXC_DISABLED;
  int err_count = 0, checks = 0;
  dfau_top dfau_top_inst (.CLK(CLK), .RST_N(RST_N), .ISSUE_VALID(ISSUE_VALID),
    .INSTR_WORD(INSTR_WORD), .UNIT_PRESENT(UNIT_PRESENT), .UNIT_ENABLED(UNIT_ENABLED),
    .SRC_A_DATA(SRC_A_DATA), .SRC_B_DATA(SRC_B_DATA), .SRC_A_IDX(SRC_A_IDX),
    .SRC_B_IDX(SRC_B_IDX), .WB_VALID(WB_VALID), .WB_IDX(WB_IDX), .WB_DATA(WB_DATA),
    .EXC_RESERVED(EXC_RESERVED), .EXC_DISABLED(EXC_DISABLED), .CTL_WR(CTL_WR),
    .CTL_WDATA(CTL_WDATA), .CTL_STATUS(CTL_STATUS));
  dfau_regs dfau_regs_inst (.a_idx(SRC_A_IDX), .b_idx(SRC_B_IDX), .a_data(SRC_A_DATA),
    .b_data(SRC_B_DATA));
  initial forever #12.5 CLK = ~CLK;
  task give_verdict;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Sources sit in registers 1 and 2, result goes to register 3.
  task run(input [10:0] mn, input [31:0] a, input [31:0] b);
    int i;
    dfau_regs_inst.mem[1] = a;
    dfau_regs_inst.mem[2] = b;
    INSTR_WORD = {6'h00, 5'h02, 5'h01, 5'h03, mn};
    ISSUE_VALID = 1;
    @(posedge CLK);
    #1 ISSUE_VALID = 0;
    for (i = 0; i < 6 && WB_VALID !== 1 && EXC_RESERVED !== 1 && EXC_DISABLED !== 1; i++) begin
      @(posedge CLK);
      #1;
    end
    if (i == 6) begin
      err_count++;
      give_verdict;
    end
    `CHK("ia", 5'h01, SRC_A_IDX)
    `CHK("ib", 5'h02, SRC_B_IDX)
    if (WB_VALID === 1) `CHK("idx", 5'h03, WB_IDX)
  endtask
  task clr;
    CTL_WR = 1;
    @(posedge CLK);
    #1 CTL_WR = 0;
  endtask
  task t_sat;
    clr;
    run(`DFAU_MIN_SAT_WORD, 32'h0000_0001, 32'h0000_0002);
    `CHK("sum", 32'h0000_0003, WB_DATA)
    `CHK("flag", 1'b0, CTL_STATUS[20])
    run(`DFAU_MIN_SAT_WORD, 32'h8000_0000, 32'hFFFF_FFFF);
    `CHK("neg", `DFAU_SAT_NEG, WB_DATA)
    `CHK("flag", 1'b1, CTL_STATUS[20])
    run(`DFAU_MIN_SAT_WORD, 32'h7FFF_FFFF, 32'h0000_0001);
    `CHK("pos", `DFAU_SAT_POS, WB_DATA)
  endtask
  task t_halv;
    reg [31:0] st;
    st = CTL_STATUS;
    run(`DFAU_MIN_HALV_PH, 32'h7FFF_8001, 32'h0001_8000);
    `CHK("hph", 32'h4000_8000, WB_DATA)
    run(`DFAU_MIN_RHALV_PH, 32'h7FFF_8001, 32'h0001_8000);
    `CHK("rph", 32'h4000_8001, WB_DATA)
    run(`DFAU_MIN_HALV_W, 32'h7FFF_FFFF, 32'h0000_0002);
    `CHK("hw", 32'h4000_0000, WB_DATA)
    run(`DFAU_MIN_RHALV_W, 32'h7FFF_FFFF, 32'h0000_0002);
    `CHK("rw", 32'h4000_0001, WB_DATA)
    `CHK("st", st, CTL_STATUS)
  endtask
  task t_carry;
    run(`DFAU_MIN_SET_CARRY, 32'hFFFF_FFFF, 32'h0000_0002);
    `CHK("csum", 32'h0000_0001, WB_DATA)
    `CHK("c1", 1'b1, CTL_STATUS[13])
    `CHK("ovf1", 1'b1, CTL_STATUS[20])
    clr;
    run(`DFAU_MIN_SET_CARRY, 32'h7FFF_FFFF, 32'h0000_0001);
    `CHK("c0", 1'b0, CTL_STATUS[13])
    `CHK("ovf0", 1'b0, CTL_STATUS[20])
  endtask
  task t_exc;
    UNIT_PRESENT = 0;
    run(`DFAU_MIN_HALV_W, 32'h0000_0001, 32'h0000_0001);
    `CHK("rsv", 1'b1, EXC_RESERVED)
    UNIT_PRESENT = 1;
    UNIT_ENABLED = 0;
    repeat (3) @(posedge CLK);
    #1 run(`DFAU_MIN_SAT_WORD, 32'h0000_0001, 32'h0000_0001);
    `CHK("dis", 1'b1, EXC_DISABLED)
  endtask
  initial begin
    repeat (2) @(posedge CLK);
    #1 RST_N = 1;
    t_sat;
    t_halv;
    t_carry;
    t_exc;
    give_verdict;
  end
endmodule
